// ===== verilog/pui_regs.vh
`ifndef PUI_REGS_VH
`define PUI_REGS_VH
// initialization phases
`define PUI_ST_RESET 3'h0
`define PUI_ST_PLL 3'h1
`define PUI_ST_LOAD 3'h2
`define PUI_ST_DONE 3'h3
`define PUI_ST_PARK 3'h4
// park hold time and derived cycles at 100 MHz
`define PUI_PARK_TIME_NS 40000
`define PUI_CLK_PERIOD_NS 10
`define PUI_PARK_CYCLES (`PUI_PARK_TIME_NS / `PUI_CLK_PERIOD_NS)
// default flash load length in words
`define PUI_LOAD_WORDS 16
`endif

// ===== verilog/pui_powerup_init.v
`include "pui_regs.vh"

module pui_powerup_init #(
	parameter LOAD_WORDS = `PUI_LOAD_WORDS,
	parameter PARK_CYCLES = `PUI_PARK_CYCLES
) (
	input wire clock,
	input wire reset,
	input wire pll_locked,
	input wire park_warning_low,
	input wire flash_word_valid,
	output reg pll_enable,
	output reg flash_load_busy,
	output reg init_done,
	output reg park_done,
	output reg host_attention,
	output reg host_attention_oe,
	output reg pins_active,
	output reg illum_select_0,
	output reg illum_select_0_oe,
	output reg illum_select_1,
	output reg illum_select_1_oe,
	output reg flash_serial_clock,
	output reg flash_serial_clock_oe,
	output reg flash_serial_out,
	output reg flash_serial_out_oe,
	output reg flash_select_0_low,
	output reg flash_select_0_low_oe
);
	localparam CW = 16;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [CW-1:0] count;
	reg [CW-1:0] next_count;

	function last_count;
		input [CW-1:0] value;
		input [CW-1:0] limit;
		begin
			last_count = (value + 16'h0001 >= limit);
		end
	endfunction

	always @* begin
		next_state = state;
		next_count = count;
		case (state)
			`PUI_ST_RESET: begin
				next_state = `PUI_ST_PLL;
			end
			`PUI_ST_PLL: begin
				if (pll_locked) begin
					next_state = `PUI_ST_LOAD;
					next_count = 16'h0000;
				end
			end
			`PUI_ST_LOAD: begin
				if (flash_word_valid) begin
					next_count = count + 16'h0001;
					if (last_count(count, LOAD_WORDS[CW-1:0])) begin
						next_state = `PUI_ST_DONE;
					end
				end
			end
			`PUI_ST_DONE: begin
				if (!park_warning_low) begin
					next_state = `PUI_ST_PARK;
					next_count = 16'h0000;
				end
			end
			`PUI_ST_PARK: begin
				if (!last_count(count, PARK_CYCLES[CW-1:0])) begin
					next_count = count + 16'h0001;
				end
			end
			default: begin
				next_state = `PUI_ST_RESET;
			end
		endcase
	end

	reg next_host_attention;
	reg next_flash_load_busy;
	reg next_flash_select_0_low;
	reg next_init_done;
	reg next_park_done;

	// output levels for the phase being entered
	always @* begin
		next_host_attention = 1'b0;
		next_flash_load_busy = 1'b0;
		next_flash_select_0_low = 1'b1;
		next_init_done = 1'b0;
		next_park_done = 1'b0;
		case (next_state)
			`PUI_ST_RESET: begin
				next_host_attention = 1'b0;
			end
			`PUI_ST_PLL: begin
				next_host_attention = 1'b1;
			end
			`PUI_ST_LOAD: begin
				next_host_attention = 1'b1;
				next_flash_load_busy = 1'b1;
				next_flash_select_0_low = 1'b0;
			end
			`PUI_ST_DONE: begin
				next_init_done = 1'b1;
			end
			`PUI_ST_PARK: begin
				next_init_done = 1'b1;
				next_park_done = (state == `PUI_ST_PARK) && last_count(count, PARK_CYCLES[CW-1:0]);
			end
			default: begin
				next_host_attention = 1'b0;
			end
		endcase
	end

	// phase register and shared counter
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			state <= `PUI_ST_RESET;
			count <= 16'h0000;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	// pins go active on the first edge after release
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			pins_active <= 1'b0;
		end else begin
			pins_active <= 1'b1;
		end
	end

	// pin drivers, high impedance while in reset
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			host_attention_oe <= 1'b0;
			illum_select_0_oe <= 1'b0;
			illum_select_1_oe <= 1'b0;
			flash_serial_clock_oe <= 1'b0;
			flash_serial_out_oe <= 1'b0;
			flash_select_0_low_oe <= 1'b0;
		end else begin
			host_attention_oe <= 1'b1;
			illum_select_0_oe <= 1'b1;
			illum_select_1_oe <= 1'b1;
			flash_serial_clock_oe <= 1'b1;
			flash_serial_out_oe <= 1'b1;
			flash_select_0_low_oe <= 1'b1;
		end
	end

	// illumination selects idle low
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			illum_select_0 <= 1'b0;
			illum_select_1 <= 1'b0;
		end else begin
			illum_select_0 <= 1'b0;
			illum_select_1 <= 1'b0;
		end
	end

	// flash clock and data idle low, select follows load
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			flash_serial_clock <= 1'b0;
			flash_serial_out <= 1'b0;
			flash_select_0_low <= 1'b1;
		end else begin
			flash_serial_clock <= 1'b0;
			flash_serial_out <= 1'b0;
			flash_select_0_low <= next_flash_select_0_low;
		end
	end

	// attention line to the host
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			host_attention <= 1'b0;
		end else begin
			host_attention <= next_host_attention;
		end
	end

	// pll runs from release on
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			pll_enable <= 1'b0;
		end else begin
			pll_enable <= 1'b1;
		end
	end

	// progress and status flags
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			flash_load_busy <= 1'b0;
			init_done <= 1'b0;
			park_done <= 1'b0;
		end else begin
			flash_load_busy <= next_flash_load_busy;
			init_done <= next_init_done;
			park_done <= next_park_done;
		end
	end
endmodule

// ===== dv/pui_far_model.sv
module pui_far(
	input wire clock,
	input wire reset,
	input wire [3:0] gap,
	output logic pll_locked,
	output logic flash_word_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	int n;
	always @(posedge clock) begin
		n <= reset ? 0 : n + 1;
		pll_locked <= !reset && n > gap;
		flash_word_valid <= !reset && n > 2 * gap && n[0];
	end
endmodule

// ===== dv/pui_checker_assertions.sv
module pui_checker(
	input wire clock,
	input wire reset,
	input wire pll_locked,
	input wire flash_load_busy,
	input wire init_done,
	input wire host_attention,
	input wire host_attention_oe,
	input wire pins_active,
	input wire flash_serial_clock_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence lock_seen; $rose(flash_load_busy); endsequence
	sequence load_end; $rose(init_done); endsequence
	a_reset_hiz: assert property (disable iff (1'b0) reset ##1 reset |-> !host_attention_oe && !flash_serial_clock_oe)
		else $error("pin driven in reset");
	a_release_up: assert property ($fell(reset) |=> pins_active && host_attention && host_attention_oe)
		else $error("pins idle after release");
	a_lock_first: assert property (lock_seen |-> $past(pll_locked))
		else $error("load before lock");
	a_done_fall: assert property (load_end |-> $fell(host_attention) && !flash_load_busy)
		else $error("attention not low at done");
	a_single_fall: assert property ($fell(host_attention) |-> init_done)
		else $error("attention glitch");
	a_no_rehigh: assert property (init_done |-> !host_attention)
		else $error("attention high after done");
endmodule
bind pui_powerup_init pui_checker pui_checker_i(.*);

// ===== dv/test_pui_powerup_init.sv
module test_pui_powerup_init;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, reset = 1, park_warning_low = 1, pll_locked, flash_word_valid;
	logic init_done, park_done, host_attention, host_attention_oe, flash_serial_clock_oe;
	logic pll_enable, flash_load_busy, pins_active, illum_select_0, illum_select_0_oe, illum_select_1;
	logic illum_select_1_oe, flash_serial_clock, flash_serial_out, flash_serial_out_oe;
	logic flash_select_0_low, flash_select_0_low_oe;
	logic [3:0] gap = 2;
	int errors = 0, comparisons = 0;
	always #5 clock = ~clock;
	pui_far pui_far_i(.clock, .reset, .gap, .pll_locked, .flash_word_valid);
	pui_powerup_init #(.LOAD_WORDS(4), .PARK_CYCLES(8)) pui_powerup_init_i(.clock, .reset, .pll_locked,
		.park_warning_low, .flash_word_valid, .pll_enable, .flash_load_busy, .init_done, .park_done,
		.host_attention, .host_attention_oe, .pins_active, .illum_select_0, .illum_select_0_oe,
		.illum_select_1, .illum_select_1_oe, .flash_serial_clock, .flash_serial_clock_oe,
		.flash_serial_out, .flash_serial_out_oe, .flash_select_0_low, .flash_select_0_low_oe);
	task automatic check(input string what, input logic exp, input logic seen);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic wait_for(ref logic s);
		for (int k = 0; k < 300 && s !== 1; k++) @(posedge clock) #1;
		if (s !== 1) begin
			errors++;
			wrap_up;
		end
	endtask
	task automatic boot(input logic [3:0] g);
		@(posedge clock) #1;
		gap = g;
		reset = 1;
		park_warning_low = 1;
		repeat (16) @(posedge clock);
		#1 check("attention oe", 0, host_attention_oe);
		check("flash clock oe", 0, flash_serial_clock_oe);
		check("illum 0 oe", 0, illum_select_0_oe);
		check("illum 1 oe", 0, illum_select_1_oe);
		check("flash out oe", 0, flash_serial_out_oe);
		check("flash select oe", 0, flash_select_0_low_oe);
		check("pins active", 0, pins_active);
		check("pll enable", 0, pll_enable);
		check("illum 0", 0, illum_select_0);
		check("flash select", 1, flash_select_0_low);
		reset = 0;
		@(posedge clock) #1 check("attention", 1, host_attention);
		check("attention oe", 1, host_attention_oe);
		check("pins active", 1, pins_active);
		check("illum 1 oe", 1, illum_select_1_oe);
		check("flash select oe", 1, flash_select_0_low_oe);
		check("flash out oe", 1, flash_serial_out_oe);
		check("pll enable", 1, pll_enable);
		check("load busy", 0, flash_load_busy);
		wait_for(flash_load_busy);
		check("flash select", 0, flash_select_0_low);
		check("attention", 1, host_attention);
		check("init done", 0, init_done);
		wait_for(init_done);
		check("attention", 0, host_attention);
		check("load busy", 0, flash_load_busy);
		check("flash select", 1, flash_select_0_low);
		check("illum 1", 0, illum_select_1);
		check("flash clock", 0, flash_serial_clock);
		check("flash out", 0, flash_serial_out);
	endtask
	task automatic park;
		park_warning_low = 0;
		repeat (8) @(posedge clock);
		#1 check("park done", 0, park_done);
		@(posedge clock) #1 check("park done", 1, park_done);
		check("init done", 1, init_done);
		check("attention", 0, host_attention);
	endtask
	initial begin
		boot(2);
		park;
		boot(9);
		park;
		wrap_up;
	end
endmodule
